// ### inc/tmr_pkg.sv
// Constants, types and register map of the capture/reload/baud timer
// Functional notes
// - Count machine cycles (state times in baud mode) or external falling edges
// - Capture mode: free 16-bit count, overflow flag
// - Trigger fall copies count into capture bytes
// - Trigger fall sets edge flag when enabled
// - Auto-reload: rollover sets flag and reloads
// - Auto-reload: trigger fall also reloads, sets flag
// - Either clock select bit forces baud mode
// - Baud mode: rollover reloads both count bytes
// - Serial bit rate is overflow rate over 16
// - Machine cycle is twelve clocks, state two
// - Internal baud rate is clock/32/(65536-reload)
// - Clock select bits route overflows rx/tx
// - Baud mode: no overflow flag, trigger no reload
// - Interrupt is OR of flags, software clears
// - Counts only while run bit set
package tmr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets on APB
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RCL  = 8'h04;
  localparam logic [7:0] OFS_RCH  = 8'h08;
  localparam logic [7:0] OFS_CNTL = 8'h0C;
  localparam logic [7:0] OFS_CNTH = 8'h10;

  // Control bit positions, most significant first
  localparam int BIT_TF   = 7;
  localparam int BIT_EXF  = 6;
  localparam int BIT_RCLK = 5;
  localparam int BIT_TRANSMIT_CLOCK_SELECT = 4;
  localparam int BIT_EXEN = 3;
  localparam int BIT_RUN  = 2;
  localparam int BIT_CSEL = 1;
  localparam int BIT_CAP  = 0;

  // Reset values and the rollover count value
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [15:0] CNT_RST  = 16'h0000;
  localparam logic [15:0] RCAP_RST = 16'h0000;
  localparam logic [15:0] CNT_MAX  = 16'hFFFF;

  // Timing: clock period, machine cycle and state time in picoseconds
  localparam int CLK_PERIOD_PS = 5000;
  localparam int MACHINE_PS    = 60000;
  localparam int STATE_PS      = 10000;
  localparam int MACHINE_CYC   = (MACHINE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STATE_CYC     = (STATE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int BAUD_DIV      = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic overflow_flag;
    logic external_edge_flag;
    logic receive_clock_select;
    logic transmit_clock_select;
    logic external_edge_enable;
    logic run_control;
    logic counter_select;
    logic capture_reload_select;
  } tmr_ctrl_type;

  typedef enum logic [1:0] {
    MODE_RELOAD,
    MODE_CAPTURE,
    MODE_BAUD
  } tmr_mode_type;

endpackage

// ### tb/tmr_far_end.sv
// Model of the pins and serial port around the timer
`timescale 1ns/1ps
`default_nettype none
module tmr_far_end (
  input  wire logic pclk,
  output var  logic trigger_pin,
  output var  logic count_input_pin,
  input  wire logic rx_clock_pulse,
  input  wire logic tx_clock_pulse,
  input  wire logic rx_bit_tick,
  input  wire logic tx_bit_tick
);
  int rx_n;
  int tx_n;
  int rxb_n;
  int txb_n;

  ////////////////////////////////////////////////////////////////////////////
  // Pins idle high; each level held six cycles so the filter accepts it
  initial begin
    trigger_pin     = 1'b1;
    count_input_pin = 1'b1;
  end

  task automatic trig_fall();
    @(posedge pclk) trigger_pin <= 1'b0;
    repeat (6) @(posedge pclk);
    trigger_pin <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask

  task automatic count_fall();
    @(posedge pclk) count_input_pin <= 1'b0;
    repeat (6) @(posedge pclk);
    count_input_pin <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask

  task automatic clr();
    rx_n = 0;
    tx_n = 0;
    rxb_n = 0;
    txb_n = 0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Serial side only counts the clocks it is offered
  always @(posedge pclk) begin
    rx_n  += int'(rx_clock_pulse === 1'b1);
    tx_n  += int'(tx_clock_pulse === 1'b1);
    rxb_n += int'(rx_bit_tick === 1'b1);
    txb_n += int'(tx_bit_tick === 1'b1);
  end
endmodule
`default_nettype wire

// ### tb/tmr_top_tb.sv
// Self-checking bench for the capture/reload/baud timer
`timescale 1ns/1ps
`default_nettype none
module tmr_top_tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        trigger_pin;
  logic        count_input_pin;
  logic        timer_irq;
  logic        rx_clock_pulse;
  logic        tx_clock_pulse;
  logic        rx_bit_tick;
  logic        tx_bit_tick;
  logic [32:0] exp_q[$];
  logic [15:0] rnd;
  int          error_cnt;
  int          n_compared;

  // Short dividers keep the run brief; expectations use these values
  tmr_top #(.MACHINE_DIV(3), .STATE_DIV(2), .BIT_DIV(2)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trigger_pin(trigger_pin),
    .count_input_pin(count_input_pin), .timer_irq(timer_irq),
    .rx_clock_pulse(rx_clock_pulse), .tx_clock_pulse(tx_clock_pulse),
    .rx_bit_tick(rx_bit_tick), .tx_bit_tick(tx_bit_tick)
  );

  tmr_far_end i_far (
    .pclk(pclk), .trigger_pin(trigger_pin), .count_input_pin(count_input_pin),
    .rx_clock_pulse(rx_clock_pulse), .tx_clock_pulse(tx_clock_pulse),
    .rx_bit_tick(rx_bit_tick), .tx_bit_tick(tx_bit_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock, report and compare helpers
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic complete_run();
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic near(input int got, input int exp);
    chk(33'(got >= exp - 1 && got <= exp + 1), 33'd1);
  endtask

  // APB master: request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge pclk) penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] exp);
    exp_q.push_back(exp);
    apb(1'b0, a, 8'h00);
  endtask

  task automatic w(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Monitor pairs each completed read with the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      chk({pslverr, prdata}, exp_q.pop_front());
    end
  end

  initial begin
    w(20000);
    error_cnt++;
    complete_run();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    void'($urandom(21420));
    w(2);
    presetn <= 1'b1;
    rd(tmr_pkg::OFS_CTRL, 33'h0);
    rd(tmr_pkg::OFS_CNTH, 33'h0);
    rd(8'h14, {1'b1, 32'h0});
    rnd = 16'($urandom);
    wr(tmr_pkg::OFS_RCL, rnd[7:0]);
    wr(tmr_pkg::OFS_RCH, rnd[15:8]);
    rd(tmr_pkg::OFS_RCL, {25'h0, rnd[7:0]});
    rd(tmr_pkg::OFS_RCH, {25'h0, rnd[15:8]});
    // Stopped timer keeps its count
    wr(tmr_pkg::OFS_CTRL, 8'h01);
    wr(tmr_pkg::OFS_CNTL, 8'h34);
    w(30);
    rd(tmr_pkg::OFS_CNTL, 33'h34);
    // Capture mode overflow sets the flag
    wr(tmr_pkg::OFS_CNTL, 8'hFE);
    wr(tmr_pkg::OFS_CNTH, 8'hFF);
    wr(tmr_pkg::OFS_CTRL, 8'h05);
    w(12);
    rd(tmr_pkg::OFS_CTRL, 33'h85);
    chk(timer_irq, 1'b1);
    // Capture on trigger fall
    wr(tmr_pkg::OFS_CTRL, 8'h09);
    wr(tmr_pkg::OFS_CNTL, 8'h34);
    wr(tmr_pkg::OFS_CNTH, 8'h12);
    i_far.trig_fall();
    rd(tmr_pkg::OFS_RCL, 33'h34);
    rd(tmr_pkg::OFS_RCH, 33'h12);
    rd(tmr_pkg::OFS_CTRL, 33'h49);
    chk(timer_irq, 1'b1);
    wr(tmr_pkg::OFS_CTRL, 8'h01);
    i_far.trig_fall();
    rd(tmr_pkg::OFS_CTRL, 33'h01);
    chk(timer_irq, 1'b0);
    // Reload mode: trigger forces the reload
    wr(tmr_pkg::OFS_RCL, 8'hCD);
    wr(tmr_pkg::OFS_RCH, 8'hAB);
    wr(tmr_pkg::OFS_CTRL, 8'h08);
    i_far.trig_fall();
    rd(tmr_pkg::OFS_CNTL, 33'hCD);
    rd(tmr_pkg::OFS_CNTH, 33'hAB);
    rd(tmr_pkg::OFS_CTRL, 33'h48);
    // Counter operation with rollover reload
    wr(tmr_pkg::OFS_RCL, 8'h10);
    wr(tmr_pkg::OFS_RCH, 8'h00);
    wr(tmr_pkg::OFS_CNTL, 8'hFF);
    wr(tmr_pkg::OFS_CNTH, 8'hFF);
    wr(tmr_pkg::OFS_CTRL, 8'h06);
    repeat (4) i_far.count_fall();
    rd(tmr_pkg::OFS_CNTL, 33'h13);
    rd(tmr_pkg::OFS_CNTH, 33'h00);
    rd(tmr_pkg::OFS_CTRL, 33'h86);
    // Baud mode: 16 state times of 2 clocks per overflow
    wr(tmr_pkg::OFS_RCL, 8'hF0);
    wr(tmr_pkg::OFS_RCH, 8'hFF);
    // Preset near the top, else the first rollover is 65k ticks away
    wr(tmr_pkg::OFS_CNTL, 8'hF0);
    wr(tmr_pkg::OFS_CNTH, 8'hFF);
    wr(tmr_pkg::OFS_CTRL, 8'h34);
    i_far.clr();
    w(640);
    near(i_far.rx_n, 20);
    near(i_far.tx_n, 20);
    near(i_far.rxb_n, 10);
    near(i_far.txb_n, 10);
    rd(tmr_pkg::OFS_CTRL, 33'h34);
    // Baud mode trigger: flag only, no reload
    wr(tmr_pkg::OFS_CTRL, 8'h38);
    wr(tmr_pkg::OFS_CNTL, 8'h55);
    i_far.trig_fall();
    rd(tmr_pkg::OFS_CNTL, 33'h55);
    rd(tmr_pkg::OFS_CTRL, 33'h78);
    // Receive only: transmit clock stays quiet; restart one period from top
    wr(tmr_pkg::OFS_CNTL, 8'hF0);
    wr(tmr_pkg::OFS_CTRL, 8'h24);
    i_far.clr();
    w(320);
    near(i_far.rx_n, 10);
    chk(33'(i_far.tx_n), 33'd0);
    // Software writes act like hardware on the flags
    wr(tmr_pkg::OFS_CTRL, 8'h80);
    w(3);
    chk(timer_irq, 1'b1);
    wr(tmr_pkg::OFS_CTRL, 8'h00);
    w(3);
    chk(timer_irq, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire

// ### verilog/tmr_sync.sv
// Three-stage pin synchroniser with filtered falling-edge pulse
`timescale 1ns/1ps
`default_nettype none
module tmr_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin_in,
  output var  logic fall_q
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;
  logic lvl_d;
  logic fall_d;

  ////////////////////////////////////////////////////////////////////////////
  // Level accepted only when stages two and three agree
  always_comb begin
    lvl_d  = (s2_q == s3_q) ? s3_q : lvl_q;
    fall_d = lvl_q & ~s2_q & ~s3_q;
  end

  // Idle-high pins, so reset to one to avoid a false edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q   <= 1'b1;
      s2_q   <= 1'b1;
      s3_q   <= 1'b1;
      lvl_q  <= 1'b1;
      fall_q <= 1'b0;
    end else begin
      s1_q   <= pin_in;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      lvl_q  <= lvl_d;
      fall_q <= fall_d;
    end
  end
endmodule
`default_nettype wire

// ### verilog/tmr_tick.sv
// Free-running divider giving a one-cycle tick every DIV clocks
`timescale 1ns/1ps
`default_nettype none
module tmr_tick #(
  parameter int DIV = 12
) (
  input  wire logic pclk,
  input  wire logic presetn,
  output var  logic tick_q
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          tick_d;

  ////////////////////////////////////////////////////////////////////////////
  // Wrap at DIV-1 and flag the wrap
  always_comb begin
    tick_d = (cnt_q == CW'(DIV - 1));
    cnt_d  = tick_d ? '0 : cnt_q + CW'(1);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end
endmodule
`default_nettype wire

// ### verilog/tmr_top.sv
// Capture/auto-reload/baud timer with APB register access
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module tmr_top #(
  parameter int MACHINE_DIV = tmr_pkg::MACHINE_CYC,
  parameter int STATE_DIV   = tmr_pkg::STATE_CYC,
  parameter int BIT_DIV     = tmr_pkg::BAUD_DIV
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        trigger_pin,
  input  wire logic        count_input_pin,
  output var  logic        timer_irq,
  output var  logic        rx_clock_pulse,
  output var  logic        tx_clock_pulse,
  output var  logic        rx_bit_tick,
  output var  logic        tx_bit_tick
);
  localparam int BW = (BIT_DIV > 1) ? $clog2(BIT_DIV) : 1;

  tmr_pkg::tmr_ctrl_type ctrl_q;
  tmr_pkg::tmr_ctrl_type ctrl_d;
  tmr_pkg::tmr_mode_type mode;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [15:0] rcap_q;
  logic [15:0] rcap_d;
  logic [31:0] prdata_d;
  logic        pready_d;
  logic        pslverr_d;
  logic        irq_d;
  logic        machine_tick;
  logic        state_tick;
  logic        trig_fall;
  logic        cnt_fall;
  logic        acc;
  logic        wr_ctrl;
  logic        wr_rcl;
  logic        wr_rch;
  logic        wr_cntl;
  logic        wr_cnth;
  logic        setup;
  logic        hit;
  logic        inc_src;
  logic        inc;
  logic        roll;
  logic        trig_act;
  logic [1:0]  pulse_q;
  logic [1:0]  bit_q;

  ////////////////////////////////////////////////////////////////////////////
  // Time bases and synchronised pins
  tmr_tick #(.DIV(MACHINE_DIV)) u_machine (
    .pclk    (pclk),
    .presetn (presetn),
    .tick_q  (machine_tick)
  );

  tmr_tick #(.DIV(STATE_DIV)) u_state (
    .pclk    (pclk),
    .presetn (presetn),
    .tick_q  (state_tick)
  );

  tmr_sync u_trig (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (trigger_pin),
    .fall_q  (trig_fall)
  );

  tmr_sync u_cnt (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (count_input_pin),
    .fall_q  (cnt_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB decode: answer prepared in setup, pready high in access
  always_comb begin
    setup   = psel & ~penable;
    acc     = psel & penable & pready;
    wr_ctrl = acc & pwrite & (paddr == tmr_pkg::OFS_CTRL);
    wr_rcl  = acc & pwrite & (paddr == tmr_pkg::OFS_RCL);
    wr_rch  = acc & pwrite & (paddr == tmr_pkg::OFS_RCH);
    wr_cntl = acc & pwrite & (paddr == tmr_pkg::OFS_CNTL);
    wr_cnth = acc & pwrite & (paddr == tmr_pkg::OFS_CNTH);
    hit     = 1'b1;
    prdata_d = prdata;
    case (paddr)
      tmr_pkg::OFS_CTRL: prdata_d = {24'h000000, ctrl_q};
      tmr_pkg::OFS_RCL:  prdata_d = {24'h000000, rcap_q[7:0]};
      tmr_pkg::OFS_RCH:  prdata_d = {24'h000000, rcap_q[15:8]};
      tmr_pkg::OFS_CNTL: prdata_d = {24'h000000, cnt_q[7:0]};
      tmr_pkg::OFS_CNTH: prdata_d = {24'h000000, cnt_q[15:8]};
      default: begin
        prdata_d = 32'h00000000;
        hit      = 1'b0;
      end
    endcase
    if (!setup || pwrite) begin
      prdata_d = prdata;
    end
    pready_d  = setup;
    pslverr_d = setup & ~hit;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode select and count enable
  always_comb begin
    if (ctrl_q.receive_clock_select | ctrl_q.transmit_clock_select) begin
      mode = tmr_pkg::MODE_BAUD;
    end else if (ctrl_q.capture_reload_select) begin
      mode = tmr_pkg::MODE_CAPTURE;
    end else begin
      mode = tmr_pkg::MODE_RELOAD;
    end
    // Counter select counts pin edges; else baud mode counts state times, otherwise machine cycles
    if (ctrl_q.counter_select) begin
      inc_src = cnt_fall;
    end else if (mode == tmr_pkg::MODE_BAUD) begin
      inc_src = state_tick;
    end else begin
      inc_src = machine_tick;
    end
    inc      = ctrl_q.run_control & inc_src;
    roll     = inc & (cnt_q == tmr_pkg::CNT_MAX);
    trig_act = trig_fall & ctrl_q.external_edge_enable;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Count, capture/reload and flag next values
  always_comb begin
    cnt_d  = cnt_q;
    rcap_d = rcap_q;
    ctrl_d = ctrl_q;
    if (inc) begin
      cnt_d = cnt_q + 16'h0001;
    end
    if (roll && mode != tmr_pkg::MODE_CAPTURE) begin
      cnt_d = rcap_q;
    end
    if (trig_act && mode == tmr_pkg::MODE_RELOAD) begin
      cnt_d = rcap_q;
    end
    // Software byte writes win over counting; avoid writing while running
    if (wr_cntl) begin
      cnt_d[7:0] = pwdata[7:0];
    end
    if (wr_cnth) begin
      cnt_d[15:8] = pwdata[7:0];
    end
    if (wr_rcl) begin
      rcap_d[7:0] = pwdata[7:0];
    end
    if (wr_rch) begin
      rcap_d[15:8] = pwdata[7:0];
    end
    // Capture after the software write so a real event is never lost
    if (trig_act && mode == tmr_pkg::MODE_CAPTURE) begin
      rcap_d = cnt_q;
    end
    if (wr_ctrl) begin
      ctrl_d = tmr_pkg::tmr_ctrl_type'(pwdata[7:0]);
    end
    // Hardware set beats a software clear in the same cycle
    if (roll && mode != tmr_pkg::MODE_BAUD) begin
      ctrl_d.overflow_flag = 1'b1;
    end
    if (trig_act) begin
      ctrl_d.external_edge_flag = 1'b1;
    end
    irq_d = ctrl_q.overflow_flag | ctrl_q.external_edge_flag;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q    <= tmr_pkg::tmr_ctrl_type'(tmr_pkg::CTRL_RST);
      cnt_q     <= tmr_pkg::CNT_RST;
      rcap_q    <= tmr_pkg::RCAP_RST;
      prdata    <= 32'h00000000;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      timer_irq <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      cnt_q     <= cnt_d;
      rcap_q    <= rcap_d;
      prdata    <= prdata_d;
      pready    <= pready_d;
      pslverr   <= pslverr_d;
      timer_irq <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-direction baud pulses and divide-by-16 bit ticks; 0 rx, 1 tx
  for (genvar i = 0; i < 2; i++) begin : g_baud
    logic [BW-1:0] div_q;
    logic [BW-1:0] div_d;
    logic          sel;
    logic          pulse_d;
    logic          bit_d;

    always_comb begin
      sel     = (i == 0) ? ctrl_q.receive_clock_select : ctrl_q.transmit_clock_select;
      pulse_d = sel & roll & (mode == tmr_pkg::MODE_BAUD);
      bit_d   = 1'b0;
      div_d   = div_q;
      if (!sel) begin
        div_d = '0;
      end else if (pulse_d) begin
        bit_d = (div_q == BW'(BIT_DIV - 1));
        div_d = bit_d ? '0 : div_q + BW'(1);
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        div_q      <= '0;
        pulse_q[i] <= 1'b0;
        bit_q[i]   <= 1'b0;
      end else begin
        div_q      <= div_d;
        pulse_q[i] <= pulse_d;
        bit_q[i]   <= bit_d;
      end
    end
  end

  // Outputs are the registered pulses
  assign rx_clock_pulse = pulse_q[0];
  assign tx_clock_pulse = pulse_q[1];
  assign rx_bit_tick    = bit_q[0];
  assign tx_bit_tick    = bit_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the timer behaviour
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence reload_roll_s;
    roll && mode == tmr_pkg::MODE_RELOAD && !wr_cntl && !wr_cnth;
  endsequence

  sequence baud_roll_s;
    roll && mode == tmr_pkg::MODE_BAUD && !wr_cntl && !wr_cnth;
  endsequence

  sequence cap_event_s;
    trig_act && mode == tmr_pkg::MODE_CAPTURE;
  endsequence

  irq_or_flag_a: assert property (
    (ctrl_q.overflow_flag || ctrl_q.external_edge_flag) |=> timer_irq)
    else $error("irq not raised by a pending flag");

  irq_clear_a: assert property (
    (!ctrl_q.overflow_flag && !ctrl_q.external_edge_flag) |=> !timer_irq)
    else $error("irq raised with no flag");

  reload_roll_a: assert property (
    reload_roll_s |=> (cnt_q == $past(rcap_q)) && ctrl_q.overflow_flag)
    else $error("auto-reload rollover wrong");

  baud_reload_a: assert property (
    baud_roll_s |=> cnt_q == $past(rcap_q))
    else $error("baud rollover did not reload");

  baud_no_flag_a: assert property (
    (mode == tmr_pkg::MODE_BAUD && !wr_ctrl && !ctrl_q.overflow_flag) |=>
      !ctrl_q.overflow_flag)
    else $error("overflow flag set in baud mode");

  capture_copy_a: assert property (
    cap_event_s |=> rcap_q == $past(cnt_q) ##0 ctrl_q.external_edge_flag)
    else $error("capture did not copy count");

  edge_flag_a: assert property (
    trig_act |=> ctrl_q.external_edge_flag)
    else $error("edge flag not set");

  stopped_hold_a: assert property (
    (!ctrl_q.run_control && !trig_act && !wr_cntl && !wr_cnth) |=> $stable(cnt_q))
    else $error("count moved while stopped");

  timer_rate_a: assert property (
    (inc && !ctrl_q.counter_select && mode != tmr_pkg::MODE_BAUD) |=>
      !inc [*2])
    else $error("timer advanced faster than machine cycle");

  baud_route_a: assert property (
    rx_clock_pulse |-> $past(ctrl_q.receive_clock_select && roll))
    else $error("rx pulse without rx routing");

endmodule
`default_nettype wire
